/* File: sarc_analog_model.sv */
// analog array model: per-channel level, sample and hold, comparator
// assumes sar_code and sample_track change just after rising clock edges
`timescale 1ns/1ps
module sarc_analog_model (
	// clock
	input wire logic clock,
	// from the sequencer
	input wire logic analog_on,
	input wire logic sample_track,
	input wire logic [9:0] sar_code,
	input wire logic [4:0] channel_gain_code,
	// to the sequencer
	output logic cmp_in
);
	// ==========================================
	// sample and hold
	logic [9:0] held = 10'h000;
	logic tog = 1'b0;
	always @(posedge clock) begin
		tog <= !tog;
		if (sample_track) begin
			held <= {channel_gain_code, 5'h07};
		end
	end
	// ==========================================
	// comparator
	// powered down it gives no stable answer, so it toggles
	assign cmp_in = analog_on ? (held >= sar_code) : tog;
endmodule

/* File: sarc_pkg.sv */
// constants, state type and register map of the converter sequencer
// assumes an AHB-Lite master with 32-bit single word transfers
package sarc_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_INSEL = 8'h08;
	localparam logic [7:0] OFS_RES_LO = 8'h0c;
	localparam logic [7:0] OFS_RES_HI = 8'h10;
	localparam logic [7:0] OFS_MISC = 8'h14;
	// ==========================================
	// field positions
	localparam int B_ON = 7;
	localparam int B_START = 6;
	localparam int B_ATE = 5;
	localparam int B_FLAG = 4;
	localparam int B_IE = 3;
	localparam int F_PS = 0;
	localparam int F_TS = 0;
	localparam int F_REFS = 6;
	localparam int B_LEFT = 5;
	localparam int F_MUX = 0;
	localparam int B_EXTREF = 2;
	localparam int B_REFOUT = 1;
	localparam int B_INTERNAL_CURRENT_SOURCE = 0;
	// ==========================================
	// cycle counts in converter clocks, then bit and channel counts, prescaler base, SAR start code and read default
	localparam logic [4:0] NORM_LEN = 5'h0d;
	localparam logic [4:0] FIRST_LEN = 5'h19;
	localparam logic [4:0] NORM_SAMP = 5'h01;
	localparam logic [4:0] FIRST_SAMP = 5'h0d;
	localparam logic [4:0] SAR_BITS = 5'h0a;
	localparam logic [4:0] SE_CHANNELS = 5'h0b;
	localparam logic [9:0] PRE_BASE = 10'h004;
	localparam logic [9:0] SAR_MID = 10'h200;
	localparam logic [31:0] RD_RST = 32'h0000_0000;
	// ==========================================
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PEND = 2'b01,
		ST_CONV = 2'b11
	} sarc_state_t;
endpackage

/* File: sarc_top.sv */
// converter sequencer: AHB-Lite registers, prescaler, trigger, SAR steps
// assumes the comparator and trigger inputs are asynchronous to clock
`timescale 1ns/1ps
module sarc_top import sarc_pkg::*; #(
	parameter int TRIG_N = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// trigger sources 1..TRIG_N-1, source 0 is own done flag
	input wire logic [TRIG_N-2:0] trig_in,
	// analog array
	input wire logic cmp_in,
	output logic [9:0] sar_code,
	output logic sample_track,
	output logic analog_on,
	output logic [4:0] channel_gain_code,
	output logic gain_bypass,
	output logic [1:0] reference_select,
	output logic ext_ref_pin_enable,
	output logic ref_output_enable,
	output logic current_source_on,
	// completion
	output logic conv_irq,
	output logic conv_busy
);
	// ==========================================
	// parameter check
	generate
		if (TRIG_N < 2 || TRIG_N > 8) begin : g_bad
			$error("TRIG_N must lie in 2..8");
		end
	endgenerate

	// ==========================================
	// state
	typedef struct packed {
		sarc_state_t st;
		logic on, ate, ie, flag, first, lock, left, xen, ron, internal_current_source;
		logic [2:0] ps, ts;
		logic [1:0] refs, aref;
		logic [4:0] mux, amux;
		logic [9:0] pre;
		logic [4:0] cnt;
		logic [9:0] code, res;
		logic [TRIG_N-2:0] s1, s2;
		logic tprev, c1, c2, wr;
		logic [7:0] wa;
		logic [31:0] rd;
		logic rdy, sh, irq, aon, byp, busy, resp;
	} sarc_regs_t;

	sarc_regs_t r_reg;
	sarc_regs_t r_next;
	logic done, edge_hit, tick, tsig, acc, start_req, clr_flag, free_run;
	logic [4:0] samp, len, bi;
	logic [15:0] al;

	// ==========================================
	// helpers
	function automatic logic [9:0] pre_lim(input logic [2:0] s);
		return 10'((PRE_BASE << s) - 10'h001);
	endfunction

	// returns {high, low} byte pair for the given alignment
	function automatic logic [15:0] align(input logic [9:0] v, input logic l);
		if (l) begin
			return {v, 6'h00};
		end
		return {6'h00, v};
	endfunction

	// ==========================================
	// next state
	always_comb begin
		r_next = r_reg;
		r_next.rdy = 1'b1;
		start_req = 1'b0;
		clr_flag = 1'b0;
		done = 1'b0;
		bi = 5'h00;
		free_run = r_reg.ate && r_reg.ts == 3'h0;
		samp = r_reg.first ? FIRST_SAMP : NORM_SAMP;
		len = r_reg.first ? FIRST_LEN : NORM_LEN;
		// first flop of each synchroniser feeds only the second
		r_next.s1 = trig_in;
		r_next.s2 = r_reg.s1;
		r_next.c1 = cmp_in;
		r_next.c2 = r_reg.c1;
		tsig = 1'b0;
		if (r_reg.ts != 3'h0 && 32'(r_reg.ts) < TRIG_N) begin
			tsig = r_reg.s2[r_reg.ts - 3'h1];
		end
		r_next.tprev = tsig;
		edge_hit = tsig && !r_reg.tprev;
		tick = r_reg.on && r_reg.pre == pre_lim(r_reg.ps);
		// prescaler only runs while enabled
		if (!r_reg.on || tick) begin
			r_next.pre = 10'h000;
		end else begin
			r_next.pre = 10'(r_reg.pre + 10'h001);
		end
		// ahb data phase of a write
		if (r_reg.wr) begin
			case (r_reg.wa)
				OFS_CTRL_A: begin
					r_next.on = hwdata[B_ON];
					start_req = hwdata[B_START];
					r_next.ate = hwdata[B_ATE];
					clr_flag = hwdata[B_FLAG];
					r_next.ie = hwdata[B_IE];
					r_next.ps = hwdata[F_PS+:3];
				end
				OFS_CTRL_B: r_next.ts = hwdata[F_TS+:3];
				OFS_INSEL: begin
					r_next.refs = hwdata[F_REFS+:2];
					r_next.left = hwdata[B_LEFT];
					r_next.mux = hwdata[F_MUX+:5];
				end
				OFS_MISC: begin
					r_next.xen = hwdata[B_EXTREF];
					r_next.ron = hwdata[B_REFOUT];
					r_next.internal_current_source = hwdata[B_INTERNAL_CURRENT_SOURCE];
				end
				default: begin
				end
			endcase
		end
		// sequencer
		case (r_reg.st)
			ST_IDLE: begin
				if (start_req) begin
					r_next.st = ST_PEND;
				end else if (r_reg.ate && edge_hit) begin
					r_next.st = ST_PEND;
					r_next.pre = 10'h000;
				end
			end
			ST_PEND: begin
				if (tick) begin
					r_next.st = ST_CONV;
					r_next.cnt = 5'h00;
					r_next.sh = 1'b1;
				end
			end
			ST_CONV: begin
				// further edges and start writes are dropped here
				if (tick) begin
					r_next.cnt = 5'(r_reg.cnt + 5'h01);
					if (r_reg.cnt == samp) begin
						r_next.sh = 1'b0;
						r_next.code = SAR_MID;
					end
					if (r_reg.cnt > samp &&
						r_reg.cnt <= 5'(samp + SAR_BITS)) begin
						bi = 5'(samp + SAR_BITS - r_reg.cnt);
						if (!r_reg.c2) begin
							r_next.code[bi[3:0]] = 1'b0;
						end
						if (bi != 5'h00) begin
							r_next.code[4'(bi[3:0] - 4'h1)] = 1'b1;
						end
					end
					if (r_reg.cnt == 5'(len - 5'h01)) begin
						done = 1'b1;
					end
				end
			end
			default: r_next.st = ST_IDLE;
		endcase
		if (done) begin
			if (!r_reg.lock) begin
				r_next.res = r_next.code;
			end
			r_next.first = 1'b0;
			// own flag as trigger restarts regardless of the flag
			r_next.st = free_run ? ST_PEND : ST_IDLE;
		end
		// set beats clear in the same cycle
		r_next.flag = done || (r_reg.flag && !clr_flag);
		// selections follow software while on, except inside a conversion
		if (r_reg.on && (r_reg.st != ST_CONV || done)) begin
			r_next.amux = r_reg.mux;
			r_next.aref = r_reg.refs;
		end
		if (!r_next.on) begin
			r_next.st = ST_IDLE;
			r_next.sh = 1'b0;
			r_next.first = 1'b1;
		end
		r_next.aon = r_next.on;
		r_next.busy = r_next.st == ST_CONV;
		r_next.byp = r_next.amux < SE_CHANNELS;
		r_next.irq = r_next.flag && r_next.ie;
		al = align(r_next.res, r_next.left);
		// ahb address phase
		acc = hsel && htrans[1] && hready;
		r_next.wr = acc && hwrite;
		r_next.wa = haddr[7:0];
		if (acc && !hwrite) begin
			r_next.rd = RD_RST;
			case (haddr[7:0])
				OFS_CTRL_A: begin
					r_next.rd[B_ON] = r_next.on;
					r_next.rd[B_START] = r_next.st != ST_IDLE;
					r_next.rd[B_ATE] = r_next.ate;
					r_next.rd[B_FLAG] = r_next.flag;
					r_next.rd[B_IE] = r_next.ie;
					r_next.rd[F_PS+:3] = r_next.ps;
				end
				OFS_CTRL_B: r_next.rd[F_TS+:3] = r_next.ts;
				OFS_INSEL: begin
					r_next.rd[F_REFS+:2] = r_next.refs;
					r_next.rd[B_LEFT] = r_next.left;
					r_next.rd[F_MUX+:5] = r_next.mux;
				end
				OFS_RES_LO: begin
					r_next.rd[7:0] = al[7:0];
					r_next.lock = 1'b1;
				end
				OFS_RES_HI: begin
					r_next.rd[7:0] = al[15:8];
					r_next.lock = 1'b0;
				end
				OFS_MISC: begin
					r_next.rd[B_EXTREF] = r_next.xen;
					r_next.rd[B_REFOUT] = r_next.ron;
					r_next.rd[B_INTERNAL_CURRENT_SOURCE] = r_next.internal_current_source;
				end
				default: r_next.rd = RD_RST;
			endcase
		end
	end

	// ==========================================
	// registers, frozen while ce is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// ==========================================
	// outputs
	assign hreadyout = r_reg.rdy;
	assign hresp = r_reg.resp;
	assign hrdata = r_reg.rd;
	assign sar_code = r_reg.code;
	assign sample_track = r_reg.sh;
	assign analog_on = r_reg.aon;
	assign channel_gain_code = r_reg.amux;
	assign gain_bypass = r_reg.byp;
	assign reference_select = r_reg.aref;
	assign ext_ref_pin_enable = r_reg.xen;
	assign ref_output_enable = r_reg.ron;
	assign current_source_on = r_reg.internal_current_source;
	assign conv_irq = r_reg.irq;
	assign conv_busy = r_reg.busy;

	// ==========================================
	// checks; the bench keeps ce high while they matter
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n || !ce);

	a_off_idle: assert property (
		!r_reg.on |-> r_reg.st == ST_IDLE && !r_reg.sh)
		else $error("converter active while off");

	a_pre_held: assert property (
		!r_reg.on |=> r_reg.pre == 10'h000)
		else $error("prescaler ran while off");

	a_busy_reads_start: assert property (
		acc && !hwrite && !r_reg.wr && haddr[7:0] == OFS_CTRL_A &&
		r_reg.st == ST_CONV && !done |=> hrdata[B_START])
		else $error("start bit low during conversion");

	a_done_sets_flag: assert property (
		done |=> r_reg.flag && r_reg.irq == r_reg.ie)
		else $error("done flag or irq missing");

	a_lock_keeps: assert property (
		done && r_reg.lock |=> $stable(r_reg.res))
		else $error("locked result overwritten");

	a_sel_stable: assert property (
		r_reg.st == ST_CONV && !done && r_reg.on
		|=> $stable(r_reg.amux) && $stable(r_reg.aref))
		else $error("selection moved mid conversion");

	a_edge_ignored: assert property (
		r_reg.st == ST_CONV && edge_hit && !done && !r_reg.wr
		|=> r_reg.st == ST_CONV)
		else $error("edge disturbed conversion");

	a_conv_len: assert property (
		done |-> r_reg.cnt ==
		5'((r_reg.first ? FIRST_LEN : NORM_LEN) - 5'h01) &&
		samp == (r_reg.first ? FIRST_SAMP : NORM_SAMP))
		else $error("wrong conversion length");

	a_free_run: assert property (
		done && free_run && !r_reg.wr |=> r_reg.st == ST_PEND)
		else $error("free running stopped");

	a_single_ends: assert property (
		done && !free_run && !r_reg.wr |=> r_reg.st == ST_IDLE &&
		r_reg.flag)
		else $error("single conversion did not end");

	a_trig_start: assert property (
		r_reg.st == ST_IDLE && r_reg.on && r_reg.ate && edge_hit &&
		!r_reg.wr |=> r_reg.st == ST_PEND && r_reg.pre == 10'h000)
		else $error("trigger edge did not start");

	a_one_pulse: assert property (
		edge_hit && !r_reg.wr |=> !edge_hit)
		else $error("edge pulse longer than one cycle");

	c_done: cover property (done);
	c_done_locked: cover property (done && r_reg.lock);
	c_free_run: cover property (done && free_run);
	c_trig: cover property (r_reg.st == ST_IDLE && r_reg.ate && edge_hit);
endmodule

/* File: tb_sar_adc_control_sequencer.sv */
// bench for the converter sequencer: register rows, then conversions
// assumes the sequencer is the only slave and drives hready itself
`timescale 1ns/1ps
module tb_sar_adc_control_sequencer import sarc_pkg::*; ;
	// ==========================================
	// signals
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sarc_row_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0] trig_in = 7'h00;
	logic ce = 1'b1;
	logic hreadyout, hresp, cmp_in, sample_track, analog_on, gain_bypass;
	logic ext_ref_pin_enable, ref_output_enable, current_source_on;
	logic conv_irq, conv_busy;
	logic [31:0] hrdata, q;
	logic [9:0] sar_code;
	logic [4:0] channel_gain_code;
	logic [1:0] reference_select;
	int err_count = 0;
	int check_count = 0;
	int n;
	sarc_row_t rows [7] = '{'{OFS_INSEL, 32'h1b4, 32'hb4},
		'{OFS_MISC, 32'h7, 32'h7}, '{OFS_CTRL_B, 32'h5, 32'h5},
		'{OFS_CTRL_A, 32'h2b, 32'h2b}, '{8'h18, 32'hff, 32'h0},
		'{OFS_RES_LO, 32'hff, 32'h0}, '{OFS_RES_HI, 32'hff, 32'h0}};
	always #50 clock = ~clock;
	sarc_top dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .cmp_in(cmp_in),
		.sar_code(sar_code), .sample_track(sample_track),
		.analog_on(analog_on), .channel_gain_code(channel_gain_code),
		.gain_bypass(gain_bypass), .reference_select(reference_select),
		.ext_ref_pin_enable(ext_ref_pin_enable),
		.ref_output_enable(ref_output_enable),
		.current_source_on(current_source_on), .conv_irq(conv_irq),
		.conv_busy(conv_busy));
	sarc_analog_model model_u (.clock(clock), .analog_on(analog_on),
		.sample_track(sample_track), .sar_code(sar_code),
		.channel_gain_code(channel_gain_code), .cmp_in(cmp_in));
	// ==========================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hready sampled at the falling edge is what the next rising edge sees
	task automatic phase();
		logic rdy;
		int k;
		rdy = 1'b0;
		k = 0;
		while (rdy !== 1'b1) begin
			@(negedge clock);
			rdy = hreadyout;
			q = hrdata;
			if (++k > 50) begin
				chk("hready", 32'h1, 32'h0);
				close_out();
			end
			@(posedge clock);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		phase();
		htrans <= 2'h0;
		hwdata <= d;
		phase();
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(nm, e, q);
	endtask
	// n counts the clocks until conv_busy shows the level
	task automatic wb(input logic lv);
		n = 0;
		do begin
			@(negedge clock);
			if (++n > 400) begin
				chk("busy_wait", 32'h1, 32'h0);
				close_out();
			end
		end while (conv_busy !== lv);
	endtask
	// ==========================================
	// sequence
	initial begin
		repeat (8) @(posedge clock);
		chk("rst_out", 32'({hreadyout, analog_on, conv_irq, conv_busy}), 32'h0);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].a, 1'b1, rows[i].d);
			rdc(rows[i].a, rows[i].e, "reg_row");
		end
		chk("off_mux", 32'({analog_on, channel_gain_code}), 32'h0);
		chk("misc", 32'({ext_ref_pin_enable, ref_output_enable,
			current_source_on, hresp}), 32'he);
		bus(OFS_CTRL_A, 1'b1, 32'h08);
		bus(OFS_INSEL, 1'b1, 32'hc5);
		bus(OFS_CTRL_A, 1'b1, 32'hc8);
		rdc(OFS_CTRL_A, 32'hc8, "start_bit");
		chk("applied", 32'({reference_select, gain_bypass,
			channel_gain_code}), 32'he5);
		wb(1'b1);
		wb(1'b0);
		chk("first_len", 32'(n > 80 && n < 104), 32'h1);
		chk("irq", 32'(conv_irq), 32'h1);
		rdc(OFS_CTRL_A, 32'h98, "done_a");
		rdc(OFS_RES_LO, 32'ha7, "res_lo");
		rdc(OFS_RES_HI, 32'h0, "res_hi");
		bus(OFS_CTRL_A, 1'b1, 32'hd8);
		wb(1'b1);
		wb(1'b0);
		chk("norm_len", 32'(n > 40 && n < 56), 32'h1);
		// low read locks, the next result must be dropped
		rdc(OFS_RES_LO, 32'ha7, "lock_lo");
		bus(OFS_INSEL, 1'b1, 32'h09);
		bus(OFS_CTRL_A, 1'b1, 32'hd8);
		wb(1'b1);
		wb(1'b0);
		chk("flag_lost", 32'(conv_irq), 32'h1);
		rdc(OFS_RES_HI, 32'h0, "lock_hi");
		bus(OFS_CTRL_A, 1'b1, 32'hd8);
		wb(1'b1);
		wb(1'b0);
		rdc(OFS_RES_LO, 32'h27, "ch9_lo");
		rdc(OFS_RES_HI, 32'h1, "ch9_hi");
		bus(OFS_INSEL, 1'b1, 32'h29);
		rdc(OFS_RES_LO, 32'hc0, "left_lo");
		rdc(OFS_RES_HI, 32'h49, "left_hi");
		bus(OFS_INSEL, 1'b1, 32'h05);
		bus(OFS_CTRL_A, 1'b1, 32'hd8);
		wb(1'b1);
		bus(OFS_INSEL, 1'b1, 32'h14);
		chk("mux_hold", 32'(channel_gain_code), 32'h5);
		rdc(OFS_CTRL_A, 32'hc8, "busy_a");
		wb(1'b0);
		rdc(OFS_RES_LO, 32'ha7, "old_ch");
		rdc(OFS_RES_HI, 32'h0, "old_hi");
		chk("mux_new", 32'({gain_bypass, channel_gain_code}), 32'h14);
		bus(OFS_CTRL_A, 1'b1, 32'hd8);
		wb(1'b1);
		// clock enable low must freeze the running conversion
		@(posedge clock) ce <= 1'b0;
		@(negedge clock) q = 32'(sar_code);
		repeat (20) @(negedge clock);
		chk("ce_hold", q, 32'(sar_code));
		@(posedge clock) ce <= 1'b1;
		bus(OFS_CTRL_A, 1'b1, 32'h08);
		repeat (60) @(posedge clock);
		chk("abort", 32'({analog_on, conv_busy, conv_irq}), 32'h0);
		rdc(OFS_CTRL_A, 32'h08, "abort_a");
		rdc(OFS_RES_LO, 32'ha7, "abort_lo");
		rdc(OFS_RES_HI, 32'h0, "abort_hi");
		bus(OFS_CTRL_B, 1'b1, 32'h01);
		bus(OFS_CTRL_A, 1'b1, 32'hb8);
		trig_in <= 7'h01;
		wb(1'b1);
		rdc(OFS_CTRL_A, 32'he8, "trig_busy");
		@(posedge clock) trig_in <= 7'h00;
		repeat (8) @(posedge clock);
		trig_in <= 7'h01;
		wb(1'b0);
		n = 0;
		repeat (80) begin
			@(negedge clock);
			n += int'(conv_busy === 1'b1);
		end
		chk("no_retrig", n, 32'h0);
		@(posedge clock) trig_in <= 7'h00;
		repeat (4) @(posedge clock);
		trig_in <= 7'h01;
		wb(1'b1);
		wb(1'b0);
		bus(OFS_CTRL_A, 1'b1, 32'hf8);
		wb(1'b1);
		bus(OFS_CTRL_B, 1'b1, 32'h00);
		bus(OFS_CTRL_A, 1'b1, 32'he8);
		wb(1'b1);
		repeat (3) begin
			wb(1'b0);
			wb(1'b1);
			chk("free_run", 32'(n < 10), 32'h1);
		end
		// reset in mid conversion, then the bus must work again
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(negedge clock);
		chk("mid_rst", 32'({hreadyout, analog_on, conv_irq,
			conv_busy}), 32'h0);
		@(posedge clock) rst_n <= 1'b1;
		rdc(OFS_CTRL_A, 32'h00, "rst_a");
		rdc(OFS_INSEL, 32'h00, "rst_insel");
		bus(OFS_CTRL_A, 1'b1, 32'h00);
		close_out();
	end
endmodule
